// >>> core/gfcm_pkg.sv
/*
 * gfcm_pkg: shared types and constants for the glitch-free clock mux
 * block and its single-input buffer variants.
 * Assumes every user of it runs on the one system clock mclk.
 */
package gfcm_pkg;

    // number of flops a pin-side clock passes before it is trusted
    localparam int GFCM_SYNC_DEPTH = 3;

    // number of mux inputs and of single-input buffer variants
    localparam int GFCM_NUM_IN = 2;
    localparam int GFCM_NUM_VAR = 3;

    // reset values of the captured idle level and of the outputs
    localparam logic GFCM_IDLE_RST = 1'b0;
    localparam logic GFCM_OUT_RST = 1'b0;

    // index of each input inside the control arrays
    localparam logic GFCM_IDX_FIRST = 1'b0;
    localparam logic GFCM_IDX_SECOND = 1'b1;

    typedef enum logic [2:0] {
        GFCM_ST_CFG = 3'h0,
        GFCM_ST_RUN0 = 3'h1,
        GFCM_ST_RUN1 = 3'h2,
        GFCM_ST_IDLE = 3'h3,
        GFCM_ST_LEAVE = 3'h4,
        GFCM_ST_WAIT = 3'h5
    } gfcm_state_t;

    typedef enum logic [1:0] {
        GFCM_VAR_PLAIN = 2'h0,
        GFCM_VAR_LOW_IDLE = 2'h1,
        GFCM_VAR_HIGH_IDLE = 2'h2
    } gfcm_variant_t;

    // control lines of one mux input
    typedef struct packed {
        logic enable;
        logic choose;
        logic bypass;
    } gfcm_sel_t;

endpackage : gfcm_pkg

// >>> core/gfcm_pin_sync.sv
/*
 * gfcm_pin_sync: three-flop synchroniser for a clock arriving on a pin.
 * Assumes pin is asynchronous to mclk; level moves only once the second
 * and third flops agree, so a single metastable sample never shows.
 */
`timescale 1ns/10ps
module gfcm_pin_sync
    import gfcm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    import gfcm_pkg::*;

    logic [GFCM_SYNC_DEPTH-1:0] stage;
    logic [GFCM_SYNC_DEPTH-1:0] next_stage;
    logic next_level;

    always_comb begin
        next_stage = {stage[GFCM_SYNC_DEPTH-2:0], pin};
        next_level = (stage[1] == stage[2]) ? stage[2] : level;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stage <= '0;
            level <= 1'b0;
        end else begin
            stage <= next_stage;
            level <= next_level;
        end
    end

endmodule : gfcm_pin_sync

// >>> core/gfcm_gated_buffer.sv
/*
 * gfcm_gated_buffer: single-input clock buffer in one of three variants:
 * plain pass-through, gated idling low, gated idling high.
 * Assumes clk_level is already synchronised to mclk.
 */
`timescale 1ns/10ps
module gfcm_gated_buffer
    import gfcm_pkg::*;
#(
    parameter gfcm_variant_t VARIANT = GFCM_VAR_PLAIN
)
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic clk_level,
    input wire logic enable,
    output logic clk_out
);
    import gfcm_pkg::*;

    logic gate;
    logic next_gate;
    logic next_out;

    always_comb begin
        next_gate = gate;
        next_out = clk_level;
        case (VARIANT)
            GFCM_VAR_LOW_IDLE: begin
                // enable only sampled in the low phase; a pulse runs out
                next_gate = clk_level ? gate : enable;
                next_out = clk_level & gate;
            end
            GFCM_VAR_HIGH_IDLE: begin
                next_gate = clk_level ? enable : gate;
                next_out = clk_level | ~gate;
            end
            default: begin
                next_out = clk_level;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            gate <= 1'b0;
            clk_out <= (VARIANT == GFCM_VAR_HIGH_IDLE);
        end else begin
            gate <= next_gate;
            clk_out <= next_out;
        end
    end

endmodule : gfcm_gated_buffer

// >>> core/gfcm_dual_input_clock_mux.sv
/*
 * gfcm_dual_input_clock_mux: oversampled glitch-free two-input clock mux
 * plus the three single-input buffer variants, all on mclk.
 * Assumes input clocks are well below half of mclk, and that select,
 * enable, bypass and configuration lines come from logic on mclk.
 */
`timescale 1ns/10ps
module gfcm_dual_input_clock_mux
    import gfcm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic first_clock_in,
    input wire logic second_clock_in,
    input wire logic first_enable_line,
    input wire logic second_enable_line,
    input wire logic first_choose_line,
    input wire logic second_choose_line,
    input wire logic first_bypass_edge_check,
    input wire logic second_bypass_edge_check,
    input wire logic idle_level,
    input wire logic power_up_pick_first,
    input wire logic power_up_pick_second,
    input wire logic buffer_clock_in,
    input wire logic low_idle_enable,
    input wire logic high_idle_enable,
    output logic mux_clock_out,
    output logic plain_clock_out,
    output logic low_idle_clock_out,
    output logic high_idle_clock_out
);
    import gfcm_pkg::*;

    localparam gfcm_variant_t VAR_MODE [GFCM_NUM_VAR] = '{
        GFCM_VAR_PLAIN, GFCM_VAR_LOW_IDLE, GFCM_VAR_HIGH_IDLE};

    logic [GFCM_NUM_IN:0] raw_pin;
    logic [GFCM_NUM_IN:0] pin_level;
    logic [GFCM_NUM_VAR-1:0] var_enable;
    logic [GFCM_NUM_VAR-1:0] var_out;
    logic [GFCM_NUM_IN-1:0] clk_s;
    gfcm_sel_t sel [GFCM_NUM_IN];
    logic [GFCM_NUM_IN-1:0] want;
    logic [GFCM_NUM_IN-1:0] byp;

    gfcm_state_t state;
    gfcm_state_t next_state;
    logic tgt_valid;
    logic next_tgt_valid;
    logic tgt_idx;
    logic next_tgt_idx;
    logic src_idx;
    logic next_src_idx;
    logic idle_q;
    logic next_idle_q;
    logic [GFCM_NUM_IN-1:0] clk_d;
    logic next_mux_out;

    logic cur_idx;
    logic cur_run;
    logic oth_idx;

    assign raw_pin = {buffer_clock_in, second_clock_in, first_clock_in};
    assign var_enable = {high_idle_enable, low_idle_enable, 1'b1};
    assign clk_s = pin_level[GFCM_NUM_IN-1:0];

    // the mux inputs arrive from other clocks, so each gets its own sync
    genvar gi;
    generate
        for (gi = 0; gi <= GFCM_NUM_IN; gi++) begin : g_sync
            gfcm_pin_sync u_sync (
                .mclk(mclk),
                .rst(rst),
                .pin(raw_pin[gi]),
                .level(pin_level[gi])
            );
        end
        for (gi = 0; gi < GFCM_NUM_VAR; gi++) begin : g_var
            gfcm_gated_buffer #(.VARIANT(VAR_MODE[gi])) u_buf (
                .mclk(mclk),
                .rst(rst),
                .clk_level(pin_level[GFCM_NUM_IN]),
                .enable(var_enable[gi]),
                .clk_out(var_out[gi])
            );
        end
    endgenerate

    assign sel[0] = '{first_enable_line, first_choose_line,
                      first_bypass_edge_check};
    assign sel[1] = '{second_enable_line, second_choose_line,
                      second_bypass_edge_check};

    always_comb begin
        for (int i = 0; i < GFCM_NUM_IN; i++) begin
            want[i] = sel[i].enable & sel[i].choose;
            byp[i] = sel[i].bypass;
        end
    end

    assign cur_run = (state == GFCM_ST_RUN0) || (state == GFCM_ST_RUN1);
    assign cur_idx = (state == GFCM_ST_RUN1) ? GFCM_IDX_SECOND
                                              : GFCM_IDX_FIRST;
    assign oth_idx = ~cur_idx;

    // state to take once the old input is let go
    function automatic gfcm_state_t enter_state(
        input logic valid,
        input logic idx,
        input logic [GFCM_NUM_IN-1:0] bypass
    );
        gfcm_state_t st;
        st = GFCM_ST_IDLE;
        if (valid) begin
            if (bypass[idx]) begin
                st = idx ? GFCM_ST_RUN1 : GFCM_ST_RUN0;
            end else begin
                st = GFCM_ST_WAIT;
            end
        end
        return st;
    endfunction : enter_state

    always_comb begin
        next_state = state;
        next_tgt_valid = tgt_valid;
        next_tgt_idx = tgt_idx;
        next_src_idx = src_idx;
        next_idle_q = idle_q;
        next_mux_out = idle_q;
        case (state)
            GFCM_ST_CFG: begin
                next_idle_q = idle_level;
                next_mux_out = idle_level;
                if (power_up_pick_first) begin
                    next_state = GFCM_ST_RUN0;
                end else if (power_up_pick_second) begin
                    next_state = GFCM_ST_RUN1;
                end else begin
                    next_state = GFCM_ST_IDLE;
                end
            end
            GFCM_ST_RUN0, GFCM_ST_RUN1: begin
                next_mux_out = clk_s[cur_idx];
                // staying while still wanted covers the both-high case
                if (!want[cur_idx]) begin
                    next_tgt_valid = want[oth_idx];
                    next_tgt_idx = oth_idx;
                    next_src_idx = cur_idx;
                    if (byp[cur_idx]) begin
                        // park at once so a dead clock never lingers
                        next_mux_out = idle_q;
                        next_state = enter_state(want[oth_idx], oth_idx,
                                                 byp);
                    end else if (sel[cur_idx].choose) begin
                        // enable-only drop: no wait, setup is user's risk
                        next_mux_out = idle_q;
                        next_state = enter_state(want[oth_idx], oth_idx,
                                                 byp);
                    end else if (clk_s[cur_idx] == idle_q) begin
                        next_mux_out = idle_q;
                        next_state = enter_state(want[oth_idx], oth_idx,
                                                 byp);
                    end else begin
                        next_state = GFCM_ST_LEAVE;
                    end
                end
            end
            GFCM_ST_LEAVE: begin
                // old clock keeps driving until it reaches the park level or its bypass is set
                next_mux_out = clk_s[src_idx];
                if (clk_s[src_idx] == idle_q || byp[src_idx]) begin
                    next_mux_out = idle_q;
                    next_state = enter_state(tgt_valid, tgt_idx,
                                             byp);
                end
            end
            GFCM_ST_WAIT: begin
                if (!want[tgt_idx]) begin
                    next_state = GFCM_ST_IDLE;
                end else if (byp[tgt_idx] ||
                             (clk_d[tgt_idx] != idle_q &&
                              clk_s[tgt_idx] == idle_q)) begin
                    // new clock just reached the park level (no seam), or its bypass is set
                    next_state = tgt_idx ? GFCM_ST_RUN1
                                         : GFCM_ST_RUN0;
                end
            end
            GFCM_ST_IDLE: begin
                next_tgt_idx = want[1];
                next_tgt_valid = want[0] ^ want[1];
                if (want[0] ^ want[1]) begin
                    next_state = enter_state(1'b1, want[1], byp);
                end
            end
            default: begin
                next_state = GFCM_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state <= GFCM_ST_CFG;
            tgt_valid <= 1'b0;
            tgt_idx <= GFCM_IDX_FIRST;
            src_idx <= GFCM_IDX_FIRST;
            idle_q <= GFCM_IDLE_RST;
            clk_d <= '0;
            mux_clock_out <= GFCM_OUT_RST;
            plain_clock_out <= GFCM_OUT_RST;
            low_idle_clock_out <= GFCM_OUT_RST;
            high_idle_clock_out <= GFCM_OUT_RST;
        end else begin
            state <= next_state;
            tgt_valid <= next_tgt_valid;
            tgt_idx <= next_tgt_idx;
            src_idx <= next_src_idx;
            idle_q <= next_idle_q;
            clk_d <= clk_s;
            mux_clock_out <= next_mux_out;
            plain_clock_out <= var_out[0];
            low_idle_clock_out <= var_out[1];
            high_idle_clock_out <= var_out[2];
        end
    end

    AST_RUN_FOLLOWS: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_RUN1 && want[1] |=> mux_clock_out == $past(clk_s[1])
    ) else $error("output does not follow the second input");

    AST_HOLD_BOTH: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_RUN0 && want[0] && want[1] |=> state == GFCM_ST_RUN0
    ) else $error("both pairs high dropped the old input");

    AST_NONE_IDLE: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_IDLE && !want[0] && !want[1]
        |=> mux_clock_out == idle_q && $stable(mux_clock_out)
    ) else $error("output moved with no input selected");

    AST_PARK_LEVEL: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_WAIT |=> mux_clock_out == idle_q
    ) else $error("output not parked while waiting for new clock");

    AST_LEAVE_EDGE: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_LEAVE && clk_s[src_idx] == idle_q
        |=> state != GFCM_ST_LEAVE && mux_clock_out == idle_q
    ) else $error("leave phase missed the old clock park edge");

    AST_SAFE_LEAVE: assert property (
        @(posedge mclk) disable iff (rst)
        cur_run && !want[cur_idx] && sel[cur_idx].enable && !byp[cur_idx]
        && clk_s[cur_idx] != idle_q |=> state == GFCM_ST_LEAVE
    ) else $error("choose-line switch did not wait for the old edge");

    AST_BYPASS: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_RUN0 && !want[0] && byp[0] && want[1] && byp[1]
        |=> state == GFCM_ST_RUN1
    ) else $error("bypass did not switch at once");

    AST_CE_FAST: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_RUN0 && first_choose_line && !first_enable_line
        && want[1] && !byp[1] |=> state == GFCM_ST_WAIT
    ) else $error("enable-only switch waited for the old clock");

    AST_CFG_IDLE: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_CFG |=> mux_clock_out == idle_q
    ) else $error("output not at idle level after configuration");

    AST_PRESELECT: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_CFG && power_up_pick_first |=> state == GFCM_ST_RUN0
    ) else $error("power-up pick of the first input ignored");

    AST_RUN0_FOLLOWS: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_RUN0 && want[0] |=> mux_clock_out == $past(clk_s[0])
    ) else $error("output does not follow the first input");

    AST_HOLD_BOTH_SECOND: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_RUN1 && want[0] && want[1] |=> state == GFCM_ST_RUN1
    ) else $error("both pairs high dropped the second input");

    AST_IDLE_STAYS: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_IDLE && want[0] == want[1] |=> state == GFCM_ST_IDLE
    ) else $error("idle left without a single valid pair");

    AST_WAIT_HOLD: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_WAIT && want[tgt_idx] && !byp[tgt_idx]
        && !(clk_d[tgt_idx] != idle_q && clk_s[tgt_idx] == idle_q)
        |=> state == GFCM_ST_WAIT
    ) else $error("new clock taken before its park edge");

    AST_LEAVE_DRIVES: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_LEAVE && clk_s[src_idx] != idle_q && !byp[src_idx]
        |=> state == GFCM_ST_LEAVE && mux_clock_out != idle_q
    ) else $error("old clock pulse cut short while leaving");

    AST_IDLE_CAPTURE: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_CFG |=> idle_q == $past(idle_level)
    ) else $error("idle level not captured at configuration");

    AST_PRESELECT_SECOND: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_CFG && !power_up_pick_first && power_up_pick_second
        |=> state == GFCM_ST_RUN1
    ) else $error("power-up pick of the second input ignored");

    AST_BYPASS_PARK: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_RUN0 && !want[0] && byp[0]
        |=> state != GFCM_ST_RUN0 && mux_clock_out == idle_q
    ) else $error("bypassed input not left at once");

    AST_ENABLE_PARK: assert property (
        @(posedge mclk) disable iff (rst)
        state == GFCM_ST_RUN1 && second_choose_line && !second_enable_line
        |=> state != GFCM_ST_RUN1 && mux_clock_out == idle_q
    ) else $error("enable-only drop waited for the old clock");

endmodule : gfcm_dual_input_clock_mux

// >>> verif/gfcm_clock_source.sv
/*
 * gfcm_clock_source: far-side model of the three input clock sources.
 * Assumes nothing of mclk; the clocks are unrelated and free-running, except that hold_first stops clk_first.
 */
`timescale 1ns/10ps
module gfcm_clock_source #(
    parameter int HALF0 = 437,
    parameter int HALF1 = 713,
    parameter int HALFB = 391
)
(
    input wire logic hold_first,
    output logic clk_first,
    output logic clk_second,
    output logic clk_buf
);
    initial clk_first = 1'h0;
    initial clk_second = 1'h1;
    initial clk_buf = 1'h0;
    // a held source models a failed oscillator stuck at its level
    always begin
        #(HALF0);
        if (!hold_first) begin
            clk_first = ~clk_first;
        end
    end
    always #(HALF1) clk_second = ~clk_second;
    always #(HALFB) clk_buf = ~clk_buf;
endmodule : gfcm_clock_source

// >>> verif/testbench.sv
/*
 * testbench: self-checking bench for the clock mux and its buffers.
 * Assumes gfcm_clock_source drives the input clocks; run lengths of
 * every output are measured in mclk cycles and set against the model.
 */
`timescale 1ns/10ps
module testbench;
    localparam int H0 = 437;
    localparam int H1 = 713;
    localparam int HB = 391;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic e0 = 1'h0, c0 = 1'h0, e1 = 1'h0, c1 = 1'h0;
    logic b0 = 1'h0, b1 = 1'h0, idle = 1'h0, pk0 = 1'h0, pk1 = 1'h0;
    logic ben_lo = 1'h1, ben_hi = 1'h1, hold = 1'h0;
    logic ck0, ck1, ckb;
    wire [3:0] outs;
    logic [3:0] prev;
    logic [15:0] rnd = 16'h58b6;
    int run [4], minrun [4], lastrun [4], flips [4];
    int cycles = 0, bad_count = 0, num_checks = 0;

    always #25 mclk = ~mclk;

    gfcm_clock_source #(.HALF0(H0), .HALF1(H1), .HALFB(HB)) src (
        .hold_first(hold), .clk_first(ck0),
        .clk_second(ck1), .clk_buf(ckb));
    gfcm_dual_input_clock_mux uut (.mclk(mclk), .rst(rst),
        .first_clock_in(ck0), .second_clock_in(ck1),
        .first_enable_line(e0), .second_enable_line(e1),
        .first_choose_line(c0), .second_choose_line(c1),
        .first_bypass_edge_check(b0), .second_bypass_edge_check(b1),
        .idle_level(idle), .power_up_pick_first(pk0),
        .power_up_pick_second(pk1), .buffer_clock_in(ckb),
        .low_idle_enable(ben_lo), .high_idle_enable(ben_hi),
        .mux_clock_out(outs[0]), .plain_clock_out(outs[1]),
        .low_idle_clock_out(outs[2]), .high_idle_clock_out(outs[3]));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : chk

    function automatic logic near(int cyc, int half);
        return (cyc * 50 >= half - 120) && (cyc * 50 <= half + 120);
    endfunction : near

    function automatic logic [15:0] lfsr_next(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // run-length monitor: a short run on any output is a glitch
    always @(posedge mclk) begin
        cycles++;
        for (int i = 0; i < 4; i++) begin
            if (outs[i] !== prev[i]) begin
                flips[i]++;
                lastrun[i] = run[i];
                if (run[i] < minrun[i]) begin
                    minrun[i] = run[i];
                end
                run[i] = 1;
            end else begin
                run[i]++;
            end
        end
        prev = outs;
        if (cycles == 6000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic wait_n(int n);
        repeat (n) @(posedge mclk);
        @(negedge mclk);
    endtask : wait_n

    task automatic clr();
        for (int i = 0; i < 4; i++) begin
            minrun[i] = 9999;
            flips[i] = 0;
        end
    endtask : clr

    task automatic ctl(logic [3:0] v);
        @(posedge mclk);
        {e0, c0, e1, c1} <= v;
    endtask : ctl

    task automatic settle_on(logic [3:0] v, int half, string what);
        ctl(v);
        clr();
        wait_n(120);
        chk(what, near(lastrun[0], half), 1'h1);
    endtask : settle_on

    initial begin
        repeat (20) @(posedge mclk);
        @(negedge mclk);
        chk("mux_in_reset", outs[0], 1'h0);
        @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        @(negedge mclk);
        chk("mux_after_cfg", outs[0], idle);
        clr();
        wait_n(60);
        chk("unconfigured_static", flips[0], 0);
        settle_on(4'hc, H0, "first_run");
        ctl(4'hf);
        clr();
        wait_n(80);
        chk("both_keep_old", near(lastrun[0], H0), 1'h1);
        for (int k = 0; k < 4; k++) begin
            rnd = lfsr_next(rnd);
            wait_n(rnd[3:0]);
            settle_on(k[0] ? 4'hc : 4'h3, k[0] ? H0 : H1, "sw_run");
            chk("sw_no_glitch", minrun[0] >= 5, 1'h1);
        end
        // old source dies high: with its choose line dropped, only the bypass lets the mux leave it
        @(posedge ck0);
        @(posedge mclk);
        hold <= 1'h1;
        b0 <= 1'h1;
        settle_on(4'h3, H1, "bypass_leave");
        @(posedge mclk);
        hold <= 1'h0;
        b0 <= 1'h0;
        settle_on(4'hd, H0, "back_first");
        @(posedge ck0);
        @(posedge mclk);
        hold <= 1'h1;
        settle_on(4'h7, H1, "enable_switch");
        @(posedge mclk);
        hold <= 1'h0;
        chk("plain_run", near(lastrun[1], HB), 1'h1);
        chk("low_run", near(lastrun[2], HB), 1'h1);
        chk("high_run", near(lastrun[3], HB), 1'h1);
        @(posedge mclk);
        ben_lo <= 1'h0;
        ben_hi <= 1'h0;
        // a pulse under way finishes, then six flops of lag
        wait_n(20);
        clr();
        wait_n(60);
        chk("low_blocked", flips[2], 0);
        chk("low_parked", outs[2], 1'h0);
        chk("high_blocked", flips[3], 0);
        chk("high_parked", outs[3], 1'h1);
        clr();
        for (int j = 0; j < 60; j++) begin
            rnd = lfsr_next(rnd);
            @(posedge mclk);
            ben_lo <= rnd[0];
            ben_hi <= rnd[1];
            repeat (rnd[4:2]) @(posedge mclk);
        end
        wait_n(2);
        chk("low_whole_pulses", minrun[2] >= 5, 1'h1);
        chk("high_whole_pulses", minrun[3] >= 5, 1'h1);
        // second configuration: idle high, second input preselected
        @(posedge mclk);
        rst <= 1'h1;
        idle <= 1'h1;
        pk1 <= 1'h1;
        {e0, c0, e1, c1} <= 4'h3;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        @(posedge mclk);
        @(negedge mclk);
        chk("mux_cfg_high", outs[0], 1'h1);
        clr();
        wait_n(100);
        chk("preselect_run", near(lastrun[0], H1), 1'h1);
        settle_on(4'hc, H0, "rise_switch");
        chk("rise_no_glitch", minrun[0] >= 5, 1'h1);
        ctl(4'h0);
        // the old clock may need a whole low phase to reach park level
        wait_n(20);
        clr();
        wait_n(60);
        chk("idle_high_static", flips[0], 0);
        chk("idle_high_level", outs[0], 1'h1);
        wrap_up();
    end
endmodule : testbench
